// >>> shared/bfhg_pkg.sv
// constants and carrier types for the buck gate sequencer
// assumes a single 25 MHz system clock and comparator levels from the analog front end
package bfhg_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 40;

  // duty limits
  localparam int DUTY_MAX_PCT      = 85;
  localparam int DUTY_FAST_PCT     = 75;
  localparam int DUTY_HIGH_VIN_PCT = 60;
  localparam int FSW_LIMIT_KHZ     = 500;
  localparam int CLK_KHZ           = 25000;
  localparam int PCT_FULL          = 100;

  // release path timing
  localparam int DRV_DELAY_NS     = 50;
  localparam int DET_DELAY_NS     = 20;
  localparam int BLANK_TIMEOUT_NS = 400;
  localparam int DRV_DELAY_CLKS   = (DRV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DET_DELAY_CLKS   = (DET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_MIN_CLKS   = DRV_DELAY_CLKS + DET_DELAY_CLKS;
  localparam int BLANK_MAX_CLKS   = BLANK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int BLANK_W          = 4;

  // fault counter
  localparam int             FAULT_W     = 3;
  localparam logic [FAULT_W-1:0] FAULT_LIMIT = 3'h7;
  localparam logic [FAULT_W-1:0] FAULT_ZERO  = 3'h0;
  localparam logic [FAULT_W-1:0] FAULT_ONE   = 3'h1;

  // hiccup soft-start length
  localparam int HICCUP_SS_NS   = 1000000;
  localparam int HICCUP_SS_CLKS = HICCUP_SS_NS / CLK_PERIOD_NS;

  // default switching period in system clocks
  localparam int SW_PERIOD_CLKS = 50;

  // operating states
  typedef enum logic [2:0] {
    BFHG_ST_OFF,
    BFHG_ST_SOFT,
    BFHG_ST_NORMAL,
    BFHG_ST_OV,
    BFHG_ST_HICCUP
  } bfhg_state_t;

  // comparator levels from the analog front end
  typedef struct packed {
    logic supply_above_start;
    logic supply_above_stop;
    logic ramp_ok;
    logic pwm_cmp;
    logic ss_below_shutdown;
    logic ss_above_ref;
    logic overvoltage;
    logic vin_above_2x_start;
    logic oc_cmp;
    logic sw_near_supply;
    logic current_limit_node_far;
  } bfhg_sense_t;

  localparam bfhg_sense_t SENSE_RESET = '0;

endpackage

// >>> src/bfhg_fault_counter.sv
// saturating three-bit overcurrent fault counter
// assumes cycle_end and hiccup_step are one-clock pulses on sys_clk
`timescale 1ns/1ps
module bfhg_fault_counter
  import bfhg_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // events
  input  wire logic               clear,
  input  wire logic               cycle_end,
  input  wire logic               oc_seen,
  input  wire logic               hiccup_step,
  // state
  output logic [FAULT_W-1:0]      count_q,
  output logic                    at_limit
);

  logic [FAULT_W-1:0] count_d;
  wire                at_zero = (count_q == FAULT_ZERO);
  wire                inc     = cycle_end & oc_seen & ~at_limit;
  wire                dec     = ((cycle_end & ~oc_seen) | hiccup_step) & ~at_zero;

  assign at_limit = (count_q == FAULT_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // count up per faulted cycle, down per clean cycle or hiccup step
  assign count_d = clear ? FAULT_ZERO :
                   inc   ? count_q + FAULT_ONE :
                   dec   ? count_q - FAULT_ONE :
                           count_q;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      count_q <= FAULT_ZERO;
    else
      count_q <= count_d;
  end

endmodule

// >>> src/bfhg_blanking.sv
// current-limit node pulldown and overcurrent blanking window
// assumes start is a one-clock pulse two clocks before high-side turn-on
`timescale 1ns/1ps
module bfhg_blanking
  import bfhg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // control
  input  wire logic start,
  input  wire logic sw_near_supply,
  input  wire logic current_limit_node_far,
  // results
  output logic      pulldown_q,
  output logic      sense_en
);

  localparam logic [BLANK_W-1:0] MIN_C = BLANK_W'(BLANK_MIN_CLKS);
  localparam logic [BLANK_W-1:0] MAX_C = BLANK_W'(BLANK_MAX_CLKS);
  localparam logic [BLANK_W-1:0] ONE_C = BLANK_W'(1);

  logic [BLANK_W-1:0] cnt_q;
  logic [BLANK_W-1:0] cnt_d;
  logic               pulldown_d;

  wire sw_release = (cnt_q >= MIN_C) & sw_near_supply;
  wire timeout    = (cnt_q >= MAX_C);

  ////////////////////////////////////////////////////////////////////////////
  // pulldown held from start until switch node or timeout releases it
  assign pulldown_d = start | (pulldown_q & ~sw_release & ~timeout);
  assign cnt_d      = start ? '0 : (pulldown_q ? cnt_q + ONE_C : cnt_q);
  assign sense_en   = ~pulldown_q & ~current_limit_node_far;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pulldown_q <= 1'b0;
      cnt_q      <= '0;
    end
    else
    begin
      pulldown_q <= pulldown_d;
      cnt_q      <= cnt_d;
    end
  end

endmodule

// >>> src/bfhg_core.sv
// gate sequencer core of a synchronous buck controller
// assumes comparator levels arrive asynchronously and the analog loop sits outside
`timescale 1ns/1ps
module bfhg_core
  import bfhg_pkg::*;
#(
  parameter int SW_PERIOD   = SW_PERIOD_CLKS,
  parameter int HICCUP_CLKS = HICCUP_SS_CLKS
)
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // comparator levels
  input  wire bfhg_sense_t        sense_async,
  // gate drives
  output logic                    high_side_drive,
  output logic                    low_side_drive,
  // current limit node
  output logic                    current_limit_pulldown,
  // loop control
  output logic                    ref_select,
  output logic                    modulator_enable,
  output logic                    soft_start_restart,
  // status
  output logic                    hiccup_active,
  output logic [FAULT_W-1:0]      fault_count
);

  localparam int CW = $clog2(SW_PERIOD);
  localparam int HW = $clog2(HICCUP_CLKS);
  localparam int FSW_KHZ  = CLK_KHZ / SW_PERIOD;
  localparam int BASE_PCT = (FSW_KHZ <= FSW_LIMIT_KHZ) ? DUTY_MAX_PCT : DUTY_FAST_PCT;
  localparam logic [CW-1:0] LAST_C    = CW'(SW_PERIOD - 1);
  localparam logic [CW-1:0] MAX_ON_C  = CW'(SW_PERIOD * BASE_PCT / PCT_FULL);
  localparam logic [CW-1:0] MAX_HV_C  = CW'(SW_PERIOD * DUTY_HIGH_VIN_PCT / PCT_FULL);
  localparam logic [CW-1:0] CYC_ONE_C = CW'(1);
  localparam logic [HW-1:0] H_LAST_C  = HW'(HICCUP_CLKS - 1);
  localparam logic [HW-1:0] H_ONE_C   = HW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // states in which the gates may switch
  function automatic logic is_switching(input bfhg_state_t s);
    is_switching = (s == BFHG_ST_SOFT) | (s == BFHG_ST_NORMAL) | (s == BFHG_ST_OV);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  bfhg_sense_t meta_q;
  bfhg_sense_t sense;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      meta_q <= SENSE_RESET;
      sense  <= SENSE_RESET;
    end
    else
    begin
      meta_q <= sense_async;
      sense  <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  bfhg_state_t        state_q;
  bfhg_state_t        state_d;
  logic [CW-1:0]      cyc_q;
  logic [HW-1:0]      hic_q;
  logic               lockout_ok_q;
  logic               seen_hs_q;
  logic               hs_done_q;
  logic               oc_term_q;
  logic               oc_cycle_q;
  logic               ramp_seen_q;
  logic               hs_q;
  logic               ls_q;
  logic               ref_q;
  logic               mod_en_q;
  logic               restart_q;
  logic               hiccup_q;
  logic               sense_en;
  logic               at_limit;
  logic [FAULT_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // supply lockout with hysteresis
  wire lockout_ok_d = lockout_ok_q ? sense.supply_above_stop
                                   : sense.supply_above_start;

  ////////////////////////////////////////////////////////////////////////////
  // switching cycle timing
  wire cycle_last  = (cyc_q == LAST_C);
  wire cycle_start = (cyc_q == '0);
  wire [CW-1:0] cyc_d = cycle_last ? '0 : cyc_q + CYC_ONE_C;
  wire [CW-1:0] max_on = sense.vin_above_2x_start ? MAX_HV_C : MAX_ON_C;
  wire in_window = ~cycle_start & (cyc_q < max_on);

  ////////////////////////////////////////////////////////////////////////////
  // hiccup soft-start step timer
  wire hic_last    = (hic_q == H_LAST_C);
  wire in_hiccup   = (state_q == BFHG_ST_HICCUP);
  wire hiccup_step = in_hiccup & hic_last;
  wire [HW-1:0] hic_d = (~in_hiccup | hic_last) ? '0 : hic_q + H_ONE_C;

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent detection and pulse termination
  wire oc_trip    = sense.oc_cmp & hs_q & sense_en;
  wire oc_term_d  = oc_trip | (oc_term_q & ~cycle_start);
  wire oc_cycle_d = oc_trip | (oc_cycle_q & ~cycle_start);

  ////////////////////////////////////////////////////////////////////////////
  // modulator gating
  wire ramp_seen_d = cycle_last ? sense.ramp_ok : (ramp_seen_q | sense.ramp_ok);
  wire switching   = is_switching(state_q);
  wire go_d        = is_switching(state_d);
  wire mod_en_d    = go_d & ramp_seen_q;
  wire duty_req    = mod_en_q & sense.pwm_cmp & in_window;

  ////////////////////////////////////////////////////////////////////////////
  // gate requests per state
  wire hs_start_ok = hs_q | (current_limit_pulldown & ~hs_done_q);
  wire hs_want    = duty_req & hs_start_ok & ~oc_term_q & ~oc_trip;
  wire hs_fall    = hs_q & ~hs_want;
  wire seen_hs_d  = (state_q == BFHG_ST_SOFT) & (seen_hs_q | hs_q);
  wire hs_done_d  = ~cycle_start & (hs_done_q | hs_fall);
  logic ls_want;

  always_comb
  begin
    case (state_q)
      BFHG_ST_SOFT:   ls_want = seen_hs_q & ~hs_want;
      BFHG_ST_NORMAL: ls_want = hs_done_q & ~hs_want;
      BFHG_ST_OV:     ls_want = ~hs_want;
      default:        ls_want = 1'b0;
    endcase
  end

  wire hs_d = switching & go_d & hs_want & ~ls_q;
  wire ls_d = switching & go_d & ls_want & ~hs_q;

  ////////////////////////////////////////////////////////////////////////////
  // operating state
  wire shutdown = ~lockout_ok_q | sense.ss_below_shutdown;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BFHG_ST_OFF:
        state_d = BFHG_ST_SOFT;
      BFHG_ST_SOFT:
        if (at_limit)
          state_d = BFHG_ST_HICCUP;
        else if (sense.overvoltage)
          state_d = BFHG_ST_OV;
        else if (sense.ss_above_ref)
          state_d = BFHG_ST_NORMAL;
      BFHG_ST_NORMAL:
        if (at_limit)
          state_d = BFHG_ST_HICCUP;
        else if (sense.overvoltage)
          state_d = BFHG_ST_OV;
      BFHG_ST_OV:
        if (at_limit)
          state_d = BFHG_ST_HICCUP;
        else if (!sense.overvoltage)
          state_d = BFHG_ST_NORMAL;
      BFHG_ST_HICCUP:
        if (count == FAULT_ZERO)
          state_d = BFHG_ST_SOFT;
      default:
        state_d = BFHG_ST_OFF;
    endcase
    if (shutdown)
      state_d = BFHG_ST_OFF;
  end

  wire restart_d = (state_d == BFHG_ST_OFF) | hiccup_step;
  wire hiccup_d  = (state_d == BFHG_ST_HICCUP);

  ////////////////////////////////////////////////////////////////////////////
  // cycle and hiccup timers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      cyc_q <= '0;
      hic_q <= '0;
    end
    else
    begin
      cyc_q <= cyc_d;
      hic_q <= hic_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and control registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_q      <= BFHG_ST_OFF;
      lockout_ok_q <= 1'b0;
      oc_term_q    <= 1'b0;
      oc_cycle_q   <= 1'b0;
      ramp_seen_q  <= 1'b0;
      seen_hs_q    <= 1'b0;
      hs_done_q    <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      lockout_ok_q <= lockout_ok_d;
      oc_term_q    <= oc_term_d;
      oc_cycle_q   <= oc_cycle_d;
      ramp_seen_q  <= ramp_seen_d;
      seen_hs_q    <= seen_hs_d;
      hs_done_q    <= hs_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      hs_q      <= 1'b0;
      ls_q      <= 1'b0;
      ref_q     <= 1'b0;
      mod_en_q  <= 1'b0;
      restart_q <= 1'b1;
      hiccup_q  <= 1'b0;
    end
    else
    begin
      hs_q      <= hs_d;
      ls_q      <= ls_d;
      ref_q     <= sense.ss_above_ref;
      mod_en_q  <= mod_en_d;
      restart_q <= restart_d;
      hiccup_q  <= hiccup_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault counter and blanking
  bfhg_fault_counter u_fault (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .clear       (~lockout_ok_q),
    .cycle_end   (cycle_last & switching),
    .oc_seen     (oc_cycle_q | oc_trip),
    .hiccup_step (hiccup_step),
    .count_q     (count),
    .at_limit    (at_limit)
  );

  bfhg_blanking u_blank (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .start          (cycle_start & mod_en_q),
    .sw_near_supply (sense.sw_near_supply),
    .current_limit_node_far       (sense.current_limit_node_far),
    .pulldown_q     (current_limit_pulldown),
    .sense_en       (sense_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign high_side_drive    = hs_q;
  assign low_side_drive     = ls_q;
  assign ref_select         = ref_q;
  assign modulator_enable   = mod_en_q;
  assign soft_start_restart = restart_q;
  assign hiccup_active      = hiccup_q;
  assign fault_count        = count;

endmodule

// >>> tb/bfhg_core_sva.sv
// port assertions for the gate sequencer core
// assumes bind onto bfhg_core; sense levels pass two sync flops inside
`timescale 1ns/1ps
module bfhg_core_sva
  import bfhg_pkg::*;
#(
  parameter int SW_PERIOD   = SW_PERIOD_CLKS,
  parameter int HICCUP_CLKS = HICCUP_SS_CLKS
)
(
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               reset_n,
  // comparator levels
  input wire bfhg_sense_t        sense_async,
  // outputs watched
  input wire logic               high_side_drive,
  input wire logic               low_side_drive,
  input wire logic               current_limit_pulldown,
  input wire logic               ref_select,
  input wire logic               modulator_enable,
  input wire logic               soft_start_restart,
  input wire logic               hiccup_active,
  input wire logic [FAULT_W-1:0] fault_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////
  // blanking steps
  sequence pd_set;
    $rose(current_limit_pulldown);
  endsequence
  sequence pd_hold;
    current_limit_pulldown [*2];
  endsequence

  ////////////////////////////////////////////////////////////////
  AST_NO_OVERLAP: assert property (!(high_side_drive && low_side_drive))
    else $error("gate drives overlap");
  AST_DEAD_AFTER_HIGH: assert property ($fell(high_side_drive) |-> !low_side_drive)
    else $error("no dead cycle after high side");
  AST_DEAD_BEFORE_HIGH: assert property ($rose(high_side_drive) |-> !$past(low_side_drive))
    else $error("no dead cycle before high side");
  AST_BLANK_BEFORE_HIGH: assert property ($rose(high_side_drive) |-> current_limit_pulldown)
    else $error("high side on without blanking");
  AST_BLANK_WINDOW: assert property (pd_set |-> pd_hold ##[1:10] !current_limit_pulldown)
    else $error("blanking window length wrong");
  AST_HIGH_NEEDS_MOD: assert property (high_side_drive |-> modulator_enable)
    else $error("high side while modulator off");
  AST_HICCUP_QUIET: assert property (hiccup_active |-> !high_side_drive && !low_side_drive && !modulator_enable)
    else $error("activity during hiccup");
  AST_FAULT_ENTRY: assert property (fault_count == FAULT_LIMIT |-> ##[0:2] hiccup_active)
    else $error("no hiccup at fault limit");
  AST_FAULT_STEP: assert property ($changed(fault_count) && fault_count != FAULT_ZERO
    |-> (fault_count - $past(fault_count) == FAULT_ONE) || ($past(fault_count) - fault_count == FAULT_ONE))
    else $error("fault counter jumped");
  AST_FAULT_FLOOR: assert property ($past(fault_count) == FAULT_ZERO |-> fault_count != FAULT_LIMIT)
    else $error("fault counter wrapped");
  AST_HICCUP_DOWN: assert property ($past(hiccup_active) && hiccup_active && $changed(fault_count)
    |-> fault_count == $past(fault_count) - FAULT_ONE)
    else $error("hiccup count not falling by one");
  AST_HICCUP_EXIT: assert property ($fell(hiccup_active) |-> fault_count == FAULT_ZERO || soft_start_restart)
    else $error("hiccup left with count nonzero");
  AST_SHUTDOWN: assert property (sense_async.ss_below_shutdown [*5]
    |-> !high_side_drive && !low_side_drive && soft_start_restart)
    else $error("gates active in shutdown");
  AST_LOCKOUT: assert property (!sense_async.supply_above_stop [*5] |-> fault_count == FAULT_ZERO && !modulator_enable)
    else $error("lockout not clearing");
  AST_REF: assert property (sense_async.ss_above_ref [*4] |-> ref_select)
    else $error("reference not selected");
endmodule

bind bfhg_core bfhg_core_sva #(.SW_PERIOD(SW_PERIOD), .HICCUP_CLKS(HICCUP_CLKS)) bfhg_core_sva_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .sense_async(sense_async),
  .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
  .current_limit_pulldown(current_limit_pulldown), .ref_select(ref_select),
  .modulator_enable(modulator_enable), .soft_start_restart(soft_start_restart),
  .hiccup_active(hiccup_active), .fault_count(fault_count)
);

// >>> tb/bfhg_fet_model.sv
// power stage model: switch node and limit node seen by the comparators
// assumes gate drives from the sequencer and a short commanded by the bench
`timescale 1ns/1ps
module bfhg_fet_model
  import bfhg_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // gate drives and limit node control
  input  wire logic high_side_drive,
  input  wire logic low_side_drive,
  input  wire logic current_limit_pulldown,
  // bench command
  input  wire logic short_circuit,
  // comparator levels
  output logic      sw_near_supply,
  output logic      oc_cmp,
  output logic      current_limit_node_far
);
  logic [1:0] rise_q = 2'h0;

  // switch node rises two clocks after turn-on unless shorted
  always @(posedge sys_clk)
    rise_q <= {rise_q[0], high_side_drive && !short_circuit};
  assign sw_near_supply = rise_q[1] && high_side_drive && !low_side_drive;
  assign oc_cmp         = short_circuit && high_side_drive;
  assign current_limit_node_far       = current_limit_pulldown;
endmodule

// >>> tb/buck_fault_hiccup_gate_sequencer_bench.sv
// self-checking bench for the gate sequencer core
// assumes 25 MHz clock, power stage model on the switch side
`timescale 1ns/1ps
module buck_fault_hiccup_gate_sequencer_bench;
  import bfhg_pkg::*;
  localparam int HC = 20;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic short_circuit = 1'b0;
  bfhg_sense_t drv = SENSE_RESET;
  bfhg_sense_t sense;
  logic sw_near, oc, far, hs, ls, pd, rs, me, ssr, hic;
  logic [FAULT_W-1:0] fc;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int w, n;

  always_comb
  begin
    sense = drv;
    sense.sw_near_supply = sw_near;
    sense.oc_cmp = oc;
    sense.current_limit_node_far = far;
  end

  bfhg_core #(.SW_PERIOD(SW_PERIOD_CLKS), .HICCUP_CLKS(HC)) bfhg_core_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .sense_async(sense), .high_side_drive(hs), .low_side_drive(ls),
    .current_limit_pulldown(pd), .ref_select(rs), .modulator_enable(me), .soft_start_restart(ssr),
    .hiccup_active(hic), .fault_count(fc));
  bfhg_fet_model bfhg_fet_model_i (.sys_clk(sys_clk), .high_side_drive(hs), .low_side_drive(ls),
    .current_limit_pulldown(pd), .short_circuit(short_circuit), .sw_near_supply(sw_near), .oc_cmp(oc),
    .current_limit_node_far(far));

  ////////////////////////////////////////////////////////////////
  // clock, timeout and shared tasks
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0b seen %0b", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic pulse(output int pw);
    for (int i = 0; i < 120 && hs !== 1'b1; i++) tick(1);
    for (pw = 0; hs === 1'b1 && pw < 100; pw++) tick(1);
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_start();
    drv.supply_above_start = 1'b1;
    drv.supply_above_stop = 1'b1;
    drv.pwm_cmp = 1'b1;
    tick(300);
    chk_bit("mod_no_ramp", 1'b0, me);
    chk_bit("low_before_first", 1'b0, ls);
    drv.ramp_ok = 1'b1;
    for (n = 0; n < 200 && me !== 1'b1; n++) tick(1);
    chk_bit("mod_on", 1'b1, me);
    for (n = 0; n < 120 && pd !== 1'b1; n++) tick(1);
    chk_bit("blank_set", 1'b1, pd);
    pulse(w);
    chk_bit("width_cap", 1'b1, w > 0 && w <= SW_PERIOD_CLKS * DUTY_MAX_PCT / PCT_FULL);
    chk_bit("dead_low", 1'b0, ls);
    chk_bit("blank_free", 1'b0, pd);
    tick(1);
    chk_bit("soft_low_on", 1'b1, ls);
  endtask
  task automatic t_normal();
    drv.ss_above_ref = 1'b1;
    tick(5);
    chk_bit("ref_sel", 1'b1, rs);
    pulse(w);
    tick(1);
    chk_bit("norm_low_on", 1'b1, ls);
    drv.vin_above_2x_start = 1'b1;
    pulse(w);
    pulse(w);
    chk_bit("width_hi_vin", 1'b1, w > 0 && w <= SW_PERIOD_CLKS * DUTY_HIGH_VIN_PCT / PCT_FULL);
    drv.vin_above_2x_start = 1'b0;
    drv.overvoltage = 1'b1;
    drv.pwm_cmp = 1'b0;
    tick(5);
    for (n = 0; n < 2 * SW_PERIOD_CLKS; n++)
    begin
      chk_bit("ov_low_on", 1'b1, ls);
      tick(1);
    end
    drv.pwm_cmp = 1'b1;
    pulse(w);
    chk_bit("ov_duty_on", 1'b1, w > 0);
    drv.overvoltage = 1'b0;
  endtask
  task automatic t_fault();
    short_circuit = 1'b1;
    pulse(w);
    chk_bit("oc_cut", 1'b1, w <= BLANK_MAX_CLKS + 5);
    tick(25);
    chk_bit("oc_stay_off", 1'b0, hs);
    for (n = 0; n < 8 * SW_PERIOD_CLKS && hic !== 1'b1; n++) tick(1);
    chk_bit("hiccup_on", 1'b1, hic);
    chk_cnt("count_limit", 16'h0007, {13'h0000, fc});
    short_circuit = 1'b0;
    for (n = 0; n < 10 * HC && hic === 1'b1; n++) tick(1);
    chk_bit("hiccup_off", 1'b0, hic);
    chk_bit("hiccup_len", 1'b1, n >= 6 * HC);
    chk_cnt("count_zero", 16'h0000, {13'h0000, fc});
    for (n = 0; n < 300 && me !== 1'b1; n++) tick(1);
    chk_bit("restart", 1'b1, me);
  endtask
  task automatic t_lockout();
    drv.supply_above_start = 1'b0;
    tick(3 * SW_PERIOD_CLKS);
    chk_bit("hyst_hold", 1'b1, me);
    drv.supply_above_stop = 1'b0;
    tick(5);
    chk_bit("lock_mod", 1'b0, me);
    chk_bit("lock_high", 1'b0, hs);
    chk_cnt("lock_count", 16'h0000, {13'h0000, fc});
    drv.supply_above_start = 1'b1;
    drv.supply_above_stop = 1'b1;
    for (n = 0; n < 400 && me !== 1'b1; n++) tick(1);
    chk_bit("lock_restart", 1'b1, me);
  endtask
  task automatic t_shutdown();
    drv.ss_below_shutdown = 1'b1;
    tick(5);
    chk_bit("sd_high", 1'b0, hs);
    chk_bit("sd_low", 1'b0, ls);
    chk_bit("sd_restart", 1'b1, ssr);
    drv.ss_below_shutdown = 1'b0;
    for (n = 0; n < 400 && me !== 1'b1; n++) tick(1);
    chk_bit("sd_resume", 1'b1, me);
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    tick(20);
    chk_bit("rst_high", 1'b0, hs);
    chk_bit("rst_low", 1'b0, ls);
    chk_bit("rst_restart", 1'b1, ssr);
    chk_cnt("rst_count", 16'h0000, {13'h0000, fc});
    reset_n = 1'b1;
    t_start();
    t_normal();
    t_fault();
    t_lockout();
    t_shutdown();
    results();
  end
endmodule
